//--- hw/table_pkg.sv
// constants and carrier types of the gray-value table control block
package table_pkg;

  // register byte addresses
  localparam logic [31:0] CTRL_ADDR = 32'hf1000240;
  localparam logic [31:0] MEM_CTRL_ADDR = 32'hf1000244;
  localparam logic [31:0] INFO_ADDR = 32'hf1000248;
  localparam logic [31:0] GAMMA_ADDR = 32'hf1000ef0;
  localparam logic [31:0] WIN_INFO_ADDR = 32'hf1000ff8;
  localparam logic [31:0] WIN_ADDR = 32'hf1001000;

  // field positions
  localparam int PRESENCE_BIT = 0;
  localparam int ENABLE_BIT = 6;
  localparam int SEL_LSB = 26;
  localparam int SEL_W = 6;
  localparam int WR_EN_BIT = 5;
  localparam int TGT_LSB = 8;
  localparam int TGT_W = 8;
  localparam int OFS_LSB = 16;
  localparam int OFS_W = 16;
  localparam int BPE_LSB = 3;
  localparam int BPE_W = 5;
  localparam int CNT_LSB = 8;
  localparam int CNT_W = 8;
  localparam int MAX_LSB = 16;
  localparam int MAX_W = 16;
  localparam int WIN_SIZE_LSB = 16;

  // capabilities and sizes
  localparam int SENSOR_BITS = 6;
  localparam int OUT_BITS = 8;
  localparam logic [BPE_W-1:0] ENTRY_BITS = 5'h08;
  localparam logic [CNT_W-1:0] TABLE_COUNT = 8'h02;
  localparam int BYTES_PER_ENTRY = (int'(ENTRY_BITS) + 7) / 8;
  localparam int ENTRIES = 1 << SENSOR_BITS;
  localparam logic [MAX_W-1:0] MAX_TABLE_BYTES = 16'(ENTRIES * BYTES_PER_ENTRY);
  localparam logic [MAX_W-1:0] WINDOW_BYTES = 16'h0004;
  localparam int TOTAL_BYTES = int'(TABLE_COUNT) * int'(MAX_TABLE_BYTES);
  localparam int IDX_W = $clog2(TOTAL_BYTES);

  // reset values
  localparam logic RESET_ENABLE = 1'b0;
  localparam logic RESET_GAMMA = 1'b0;
  localparam logic RESET_WR_EN = 1'b0;
  localparam logic [SEL_W-1:0] RESET_SEL = 6'h00;
  localparam logic [TGT_W-1:0] RESET_TGT = 8'h00;
  localparam logic [OFS_W-1:0] RESET_OFS = 16'h0000;

  typedef struct packed {
    logic valid;
    logic [SENSOR_BITS-1:0] value;
  } sensor_pixel_t;

  typedef struct packed {
    logic valid;
    logic [OUT_BITS-1:0] value;
  } corrected_pixel_t;

endpackage : table_pkg

//--- hw/lookup_table_control.sv
// gray-value table selection, gamma exclusion and chunked table loading
//
// Decided for this implementation: the plain strobed port.

`timescale 1ns/1ps

module lookup_table_control (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire table_pkg::sensor_pixel_t pix_in,
  output table_pkg::corrected_pixel_t pix_out,
  output logic correction_on,
  output logic gamma_on
);

  import table_pkg::*;

  // register reached by an address
  typedef enum logic [2:0] {
    HIT_NONE = 3'h0,
    HIT_CTRL = 3'h1,
    HIT_MEM_CTRL = 3'h2,
    HIT_INFO = 3'h3,
    HIT_GAMMA = 3'h4,
    HIT_WIN_INFO = 3'h5,
    HIT_WIN = 3'h6
  } reg_hit_t;

  // address decode shared by the write and read paths
  function automatic reg_hit_t decode_reg(
    input logic [31:0] addr
  );
    reg_hit_t hit;
    hit = HIT_NONE;
    if (addr == CTRL_ADDR) begin
      hit = HIT_CTRL;
    end else if (addr == MEM_CTRL_ADDR) begin
      hit = HIT_MEM_CTRL;
    end else if (addr == INFO_ADDR) begin
      hit = HIT_INFO;
    end else if (addr == GAMMA_ADDR) begin
      hit = HIT_GAMMA;
    end else if (addr == WIN_INFO_ADDR) begin
      hit = HIT_WIN_INFO;
    end else if (addr == WIN_ADDR) begin
      hit = HIT_WIN;
    end
    return hit;
  endfunction : decode_reg

  // true while a byte offset still lies inside one table
  function automatic logic in_table(
    input logic [OFS_W-1:0] ofs
  );
    return ofs < MAX_TABLE_BYTES;
  endfunction : in_table

  // byte position of an entry inside the flat table store
  function automatic logic [IDX_W-1:0] mem_index(
    input logic [TGT_W-1:0] tbl,
    input logic [OFS_W-1:0] ofs
  );
    logic [31:0] flat;
    flat = 32'(tbl) * 32'(MAX_TABLE_BYTES) + 32'(ofs);
    return flat[IDX_W-1:0];
  endfunction : mem_index

  // built-in gamma curve on the widened gray value
  function automatic logic [OUT_BITS-1:0] gamma_curve(
    input logic [SENSOR_BITS-1:0] gray
  );
    logic [OUT_BITS-1:0] x;
    logic [15:0] lift;
    x = {gray, 2'b00};
    lift = 16'(8'hff - x) * 16'(x);
    return 8'(16'(x) + (lift >> 8));
  endfunction : gamma_curve

  // widen a sensor value to the output precision
  function automatic logic [OUT_BITS-1:0] widen(
    input logic [SENSOR_BITS-1:0] gray
  );
    return {gray, 2'b00};
  endfunction : widen

  // read words, reserved bits zero, presence bit set
  function automatic logic [31:0] ctrl_word(
    input logic enable,
    input logic [SEL_W-1:0] sel
  );
    logic [31:0] w;
    w = 32'h00000000;
    w[PRESENCE_BIT] = 1'b1;
    w[ENABLE_BIT] = enable;
    w[SEL_LSB +: SEL_W] = sel;
    return w;
  endfunction : ctrl_word

  function automatic logic [31:0] mem_ctrl_word(
    input logic wr_en,
    input logic [TGT_W-1:0] tgt,
    input logic [OFS_W-1:0] ofs
  );
    logic [31:0] w;
    w = 32'h00000000;
    w[PRESENCE_BIT] = 1'b1;
    w[WR_EN_BIT] = wr_en;
    w[TGT_LSB +: TGT_W] = tgt;
    w[OFS_LSB +: OFS_W] = ofs;
    return w;
  endfunction : mem_ctrl_word

  function automatic logic [31:0] info_word();
    logic [31:0] w;
    w = 32'h00000000;
    w[PRESENCE_BIT] = 1'b1;
    w[BPE_LSB +: BPE_W] = ENTRY_BITS;
    w[CNT_LSB +: CNT_W] = TABLE_COUNT;
    w[MAX_LSB +: MAX_W] = MAX_TABLE_BYTES;
    return w;
  endfunction : info_word

  function automatic logic [31:0] gamma_word(
    input logic enable
  );
    logic [31:0] w;
    w = 32'h00000000;
    w[PRESENCE_BIT] = 1'b1;
    w[ENABLE_BIT] = enable;
    return w;
  endfunction : gamma_word

  logic [SEL_W-1:0] active_table_index;
  logic write_access_enable;
  logic [TGT_W-1:0] target_table_index;
  logic [OFS_W-1:0] byte_offset_pointer;
  logic [7:0] table_mem [TOTAL_BYTES];

  logic ctrl_wr;
  logic mem_ctrl_wr;
  logic gamma_wr;
  logic window_wr;
  logic load_ok;
  logic [31:0] next_rdata;
  corrected_pixel_t next_pix;
  reg_hit_t addr_hit;
  logic [WINDOW_BYTES-1:0] lane_wr;
  logic [OUT_BITS-1:0] table_entry;

  // one decode of the shared address serves both strobes
  always_comb begin
    addr_hit = decode_reg(reg_addr);
  end

  // write decode
  always_comb begin
    ctrl_wr = 1'b0;
    mem_ctrl_wr = 1'b0;
    gamma_wr = 1'b0;
    window_wr = 1'b0;
    if (reg_wr) begin
      if (addr_hit == HIT_CTRL) begin
        ctrl_wr = 1'b1;
      end else if (addr_hit == HIT_MEM_CTRL) begin
        mem_ctrl_wr = 1'b1;
      end else if (addr_hit == HIT_GAMMA) begin
        gamma_wr = 1'b1;
      end else if (addr_hit == HIT_WIN) begin
        window_wr = 1'b1;
      end
    end
  end

  // chunk is taken only with write access and a valid target
  always_comb begin
    load_ok = window_wr && write_access_enable &&
              (target_table_index < TABLE_COUNT);
  end

  // lanes of a chunk that still fall inside the target table
  always_comb begin
    lane_wr = '0;
    for (int k = 0; k < int'(WINDOW_BYTES); k++) begin
      lane_wr[k] = load_ok && in_table(byte_offset_pointer + 16'(k));
    end
  end

  // table select
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      active_table_index <= RESET_SEL;
    end else if (ctrl_wr) begin
      active_table_index <= reg_wdata[SEL_LSB +: SEL_W];
    end
  end

  // correction and gamma enables: a gamma write loads both from the enable bit, a control write clears gamma
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      correction_on <= RESET_ENABLE;
      gamma_on <= RESET_GAMMA;
    end else if (ctrl_wr) begin
      correction_on <= reg_wdata[ENABLE_BIT];
      gamma_on <= 1'b0;
    end else if (gamma_wr) begin
      gamma_on <= reg_wdata[ENABLE_BIT];
      correction_on <= reg_wdata[ENABLE_BIT];
    end
  end

  // memory-access control fields
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      write_access_enable <= RESET_WR_EN;
      target_table_index <= RESET_TGT;
    end else if (mem_ctrl_wr) begin
      write_access_enable <= reg_wdata[WR_EN_BIT];
      target_table_index <= reg_wdata[TGT_LSB +: TGT_W];
    end
  end

  // byte offset: written by software, advanced by each accepted chunk
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      byte_offset_pointer <= RESET_OFS;
    end else if (mem_ctrl_wr) begin
      byte_offset_pointer <= reg_wdata[OFS_LSB +: OFS_W];
    end else if (load_ok) begin
      byte_offset_pointer <= byte_offset_pointer + WINDOW_BYTES;
    end
  end

  // table store: chunk bytes land at offset, lowest byte first
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < TOTAL_BYTES; i++) begin
        table_mem[i] <= 8'h00;
      end
    end else if (load_ok) begin
      for (int k = 0; k < int'(WINDOW_BYTES); k++) begin
        if (lane_wr[k]) begin
          table_mem[mem_index(target_table_index,
                              byte_offset_pointer + 16'(k))]
            <= reg_wdata[8*k +: 8];
        end
      end
    end
  end

  // gather one entry, lowest byte first, and keep its output bits
  always_comb begin
    logic [OFS_W-1:0] entry_ofs;
    logic [8*BYTES_PER_ENTRY-1:0] raw;
    entry_ofs = 16'(pix_in.value) * 16'(BYTES_PER_ENTRY);
    raw = '0;
    for (int b = 0; b < BYTES_PER_ENTRY; b++) begin
      raw[8*b +: 8] = table_mem[mem_index(8'(active_table_index), entry_ofs + 16'(b))];
    end
    table_entry = raw[OUT_BITS-1:0];
  end

  // pixel correction path
  always_comb begin
    next_pix.valid = pix_in.valid;
    next_pix.value = widen(pix_in.value);
    if (gamma_on) begin
      next_pix.value = gamma_curve(pix_in.value);
    end else if (correction_on &&
                 (8'(active_table_index) < TABLE_COUNT)) begin
      next_pix.value = table_entry;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pix_out <= '0;
    end else begin
      pix_out <= next_pix;
    end
  end

  // read decode, reserved bits read as zero
  always_comb begin
    next_rdata = 32'h00000000;
    if (reg_rd) begin
      if (addr_hit == HIT_CTRL) begin
        next_rdata = ctrl_word(correction_on, active_table_index);
      end else if (addr_hit == HIT_MEM_CTRL) begin
        next_rdata = mem_ctrl_word(write_access_enable, target_table_index,
                                   byte_offset_pointer);
      end else if (addr_hit == HIT_INFO) begin
        next_rdata = info_word();
      end else if (addr_hit == HIT_GAMMA) begin
        next_rdata = gamma_word(gamma_on);
      end else if (addr_hit == HIT_WIN_INFO) begin
        next_rdata[WIN_SIZE_LSB +: MAX_W] = WINDOW_BYTES;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule : lookup_table_control

//--- bench/lookup_table_control_props.sv
// port-level assertion checker for the table control block
`timescale 1ns/1ps
module lookup_table_control_props
  import table_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire table_pkg::sensor_pixel_t pix_in,
  input wire table_pkg::corrected_pixel_t pix_out,
  input wire logic correction_on,
  input wire logic gamma_on
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_wr(logic [31:0] a);
    reg_wr && reg_addr == a;
  endsequence
  a_info_read: assert property (reg_rd && reg_addr == INFO_ADDR |=>
    reg_rdata == {MAX_TABLE_BYTES, TABLE_COUNT, ENTRY_BITS, 3'h1}) else $error("info word wrong");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  a_gamma_pulls: assert property (gamma_on |-> correction_on)
    else $error("gamma on without correction");
  a_gamma_wr: assert property (s_wr(GAMMA_ADDR) |=> gamma_on == $past(reg_wdata[ENABLE_BIT])
    && correction_on == gamma_on) else $error("gamma write effect wrong");
  a_ctrl_wr: assert property (s_wr(CTRL_ADDR) |=> !gamma_on
    && correction_on == $past(reg_wdata[ENABLE_BIT])) else $error("enable write effect wrong");
  a_flags_hold: assert property (!reg_wr |=> $stable(correction_on) && $stable(gamma_on))
    else $error("flags moved without write");
  a_pix_valid: assert property (1'b1 |=> pix_out.valid == $past(pix_in.valid))
    else $error("pixel valid lost");
  a_pass_thru: assert property (pix_in.valid && !correction_on |=>
    pix_out.value == {$past(pix_in.value), 2'h0}) else $error("pass-through value wrong");
endmodule : lookup_table_control_props

//--- bench/lookup_table_control_tb_top.sv
// self-checking testbench for the table control block
`timescale 1ns/1ps
module lookup_table_control_tb_top;
  import table_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] reg_addr = 32'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  sensor_pixel_t pix_in = '0;
  corrected_pixel_t pix_out;
  logic correction_on;
  logic gamma_on;
  int n_errors = 0;
  int samples_checked = 0;
  lookup_table_control u_lookup_table_control (.sys_clk(sys_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pix_in(pix_in), .pix_out(pix_out),
    .correction_on(correction_on), .gamma_on(gamma_on));
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk("read data", exp, reg_rdata);
  endtask : rd
  task automatic px(input logic [5:0] v, input logic [7:0] exp);
    @(posedge sys_clk);
    pix_in <= '{valid: 1'b1, value: v};
    @(posedge sys_clk);
    #1 chk("pixel out", {23'h0, 1'b1, exp}, {23'h0, pix_out});
  endtask : px
  task automatic complete_run;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run
  initial begin
    #(50 * 4000);
    n_errors++;
    complete_run();
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(INFO_ADDR, 32'h00400241);
    rd(CTRL_ADDR, 32'h00000001);
    rd(GAMMA_ADDR, 32'h00000001);
    rd(WIN_INFO_ADDR, 32'h00040000);
    rd(32'hf100024c, 32'h0);
    wr(INFO_ADDR, 32'hffffffff);
    rd(INFO_ADDR, 32'h00400241);
    wr(MEM_CTRL_ADDR, 32'h00000120);
    for (int i = 0; i < 16; i++) begin
      wr(WIN_ADDR, {8'(252 - 4 * i), 8'(253 - 4 * i), 8'(254 - 4 * i), 8'(255 - 4 * i)});
    end
    rd(MEM_CTRL_ADDR, 32'h00400121);
    wr(MEM_CTRL_ADDR, 32'h0);
    wr(WIN_ADDR, 32'hffffffff);
    rd(MEM_CTRL_ADDR, 32'h00000001);
    wr(MEM_CTRL_ADDR, 32'h00000220);
    wr(WIN_ADDR, 32'h12345678);
    rd(MEM_CTRL_ADDR, 32'h00000221);
    wr(MEM_CTRL_ADDR, 32'h0);
    px(6'h05, 8'h14);
    wr(CTRL_ADDR, 32'h04000040);
    px(6'h03, 8'hfc);
    px(6'h3f, 8'hc0);
    wr(CTRL_ADDR, 32'h00000040);
    px(6'h00, 8'h00);
    wr(GAMMA_ADDR, 32'h00000040);
    #1 chk("gamma flags", 32'h3, {30'h0, gamma_on, correction_on});
    rd(GAMMA_ADDR, 32'h00000041);
    rd(CTRL_ADDR, 32'h00000041);
    px(6'h10, 8'h6f);
    wr(CTRL_ADDR, 32'h04000040);
    #1 chk("enable flags", 32'h1, {30'h0, gamma_on, correction_on});
    rd(GAMMA_ADDR, 32'h00000001);
    px(6'h03, 8'hfc);
    wr(GAMMA_ADDR, 32'h0);
    #1 chk("off flags", 32'h0, {30'h0, gamma_on, correction_on});
    complete_run();
  end
endmodule : lookup_table_control_tb_top
bind lookup_table_control lookup_table_control_props u_lookup_table_control_props (
  .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pix_in(pix_in),
  .pix_out(pix_out), .correction_on(correction_on), .gamma_on(gamma_on));
